// File: core/ccd_top.sv
/*
 * Channel divider and clock output configuration: register file for four
 * channels and eight clock outputs, channel dividers, and output gating.
 * Assumes the serial port engine presents byte writes and reads on the
 * reg_* ports, synchronous to clk_sys_in.
 */
// Notes on behaviour
// - Ratio code 0 bypasses the divider, codes 1 to 8 divide by 2, 3, 4, 6, 8, 12, 16 and 24.
// - Channels A and D reset to bypass, channels B and C to divide by four or three per the strap pin.
// - Channel power-down bit 1 shuts the channel down, reset value 0.
// - Each clock output has its own power-down bit, 1 shuts it down, reset value 0.
// - The 8-bit phase code delays the channel by that many input periods, reset zero.
// - In LVDS format amplitude 00 is 350mV, 01 is 750mV, 10 and 11 reserved, reset 01.
// - In LVPECL format amplitude 00 is 350mV, 01 is 750mV, 10 and 11 are 1000mV.
// - One amplitude field serves outputs A0 and A1, another serves B0 and B1.
// - Format bit 0 selects LVDS and 1 selects LVPECL, reset 0.
// - One format bit serves outputs A0 and A1, another serves B0 and B1.
// - Output enable 0 holds the output low, 1 lets it toggle, reset 1.
`timescale 1ns/1ps
module ccd_top (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Strap
    input wire logic middle_divider_default_strap_in,
    // Register back end of the serial port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Clock outputs, index 0..7 = A0 A1 A2 B0 B1 C0 C1 D
    output logic [ccd_pkg::CCD_OUTPUTS-1:0] clock_output_out,
    output logic [ccd_pkg::CCD_OUTPUTS-1:0] output_lvpecl_out,
    output logic [2*ccd_pkg::CCD_OUTPUTS-1:0] output_level_out,
    output logic [ccd_pkg::CCD_OUTPUTS-1:0] output_active_out,
    output logic [ccd_pkg::CCD_CHANNELS-1:0] channel_running_out
);
    import ccd_pkg::*;

    typedef struct packed {
        logic [CCD_CHANNELS-1:0][3:0] divider;
        logic [CCD_CHANNELS-1:0][7:0] phase;
        logic [CCD_CHANNELS-1:0] ch_pd;
        logic [CCD_OUTPUTS-1:0] out_pd;
        logic shared_format_first_pair;
        logic shared_format_second_channel;
        logic format_a2;
        logic format_c0;
        logic format_c1;
        logic format_d;
        logic [1:0] shared_amplitude_first_pair;
        logic [1:0] shared_amplitude_second_channel;
        logic [1:0] amp_a2;
        logic [1:0] amp_c0;
        logic [1:0] amp_c1;
        logic [1:0] amp_d;
        logic [CCD_OUTPUTS-1:0] enable;
        logic [CCD_CHANNELS-1:0] restart;
        logic [7:0] rdata;
        logic [CCD_OUTPUTS-1:0] clk_out;
    } ccd_st_t;

    ccd_st_t st_q, st_d;
    ccd_chan_if chi [CCD_CHANNELS] ();
    logic [CCD_CHANNELS-1:0] tick;
    logic [CCD_OUTPUTS-1:0] fmt;
    logic [CCD_OUTPUTS-1:0][1:0] amp;
    logic [CCD_OUTPUTS-1:0][1:0] lvl;

    // Output to channel map: A A A B B C C D
    localparam logic [CCD_OUTPUTS-1:0][1:0] OUT_CH = {2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};

    // Channel instances
    for (genvar c = 0; c < CCD_CHANNELS; c++) begin : g_ch
        ccd_channel u_ch (
            .clk_sys_in(clk_sys_in),
            .rstn_in(rstn_in),
            .ch(chi[c])
        );
        assign chi[c].ratio_code = st_q.divider[c];
        assign chi[c].phase_delay = st_q.phase[c];
        assign chi[c].power_down = st_q.ch_pd[c];
        assign chi[c].restart = st_q.restart[c];
        assign tick[c] = chi[c].tick;
        assign channel_running_out[c] = chi[c].running;
    end

    // Per-output format and amplitude fan-out
    always_comb begin
        fmt = {st_q.format_d, st_q.format_c1, st_q.format_c0, st_q.shared_format_second_channel,
               st_q.shared_format_second_channel, st_q.format_a2, st_q.shared_format_first_pair,
               st_q.shared_format_first_pair};
        amp = {st_q.amp_d, st_q.amp_c1, st_q.amp_c0, st_q.shared_amplitude_second_channel,
               st_q.shared_amplitude_second_channel, st_q.amp_a2, st_q.shared_amplitude_first_pair,
               st_q.shared_amplitude_first_pair};
        for (int i = 0; i < CCD_OUTPUTS; i++) begin
            if (fmt[i]) begin
                lvl[i] = amp[i][1] ? CCD_LVL_1000 : amp[i];
            end else begin
                lvl[i] = amp[i][1] ? CCD_LVL_UNDEF : amp[i];
            end
        end
    end

    // Register file and output gating
    always_comb begin
        logic [1:0] ch;
        logic [3:0] ofs;
        logic hit;
        st_d = st_q;
        ch = 2'(reg_addr_in[5:4] - CCD_CH_BASE_A[5:4]);
        ofs = reg_addr_in[3:0];
        hit = (reg_addr_in[7:6] == 2'h0) && (reg_addr_in[5:4] >= CCD_CH_BASE_A[5:4]) || reg_addr_in[7:4] == 4'h4
              || reg_addr_in[7:4] == 4'h5;
        st_d.restart = '0;
        // Disabled output held low
        // Enable register carries A0 in its top bit and D in bit 0, opposite to the output index
        for (int i = 0; i < CCD_OUTPUTS; i++) begin
            st_d.clk_out[i] = tick[OUT_CH[i]] & st_q.enable[CCD_OUTPUTS-1-i] & ~st_q.out_pd[i]
                              & ~st_q.ch_pd[OUT_CH[i]];
        end
        // Read data, reserved bits as zero
        st_d.rdata = 8'h00;
        if (reg_rd_in) begin
            if (reg_addr_in == CCD_ADDR_ENABLE) begin
                st_d.rdata = st_q.enable;
            end else if (hit) begin
                unique case (ofs)
                    CCD_OFS_DIVIDER: st_d.rdata = {4'h0, st_q.divider[ch]};
                    CCD_OFS_PHASE: st_d.rdata = st_q.phase[ch];
                    CCD_OFS_CH_PD: st_d.rdata = {st_q.ch_pd[ch], 7'h00};
                    default: st_d.rdata = 8'h00;
                endcase
                unique case (reg_addr_in)
                    8'h24: st_d.rdata = {st_q.out_pd[0], 2'h0, st_q.shared_format_first_pair,
                                         st_q.shared_amplitude_first_pair, 2'h0};
                    8'h25: st_d.rdata = {st_q.out_pd[1], 7'h00};
                    8'h26: st_d.rdata = {st_q.out_pd[2], 2'h0, st_q.format_a2, st_q.amp_a2, 2'h0};
                    8'h34: st_d.rdata = {st_q.out_pd[3], 2'h0, st_q.shared_format_second_channel,
                                         st_q.shared_amplitude_second_channel, 2'h0};
                    8'h35: st_d.rdata = {st_q.out_pd[4], 7'h00};
                    8'h44: st_d.rdata = {st_q.out_pd[5], 2'h0, st_q.format_c0, st_q.amp_c0, 2'h0};
                    8'h45: st_d.rdata = {st_q.out_pd[6], 2'h0, st_q.format_c1, st_q.amp_c1, 2'h0};
                    8'h54: st_d.rdata = {st_q.out_pd[7], 2'h0, st_q.format_d, st_q.amp_d, 2'h0};
                    default: ;
                endcase
            end
        end
        // Writes; divider, phase and channel power-down writes restart the channel for a clean phase
        if (reg_wr_in) begin
            if (reg_addr_in == CCD_ADDR_ENABLE) begin
                st_d.enable = reg_wdata_in;
            end else if (hit) begin
                unique case (ofs)
                    CCD_OFS_DIVIDER: begin
                        st_d.divider[ch] = reg_wdata_in[3:0];
                        st_d.restart[ch] = 1'b1;
                    end
                    CCD_OFS_PHASE: begin
                        st_d.phase[ch] = reg_wdata_in;
                        st_d.restart[ch] = 1'b1;
                    end
                    CCD_OFS_CH_PD: begin
                        st_d.ch_pd[ch] = reg_wdata_in[CCD_POS_PD];
                        st_d.restart[ch] = 1'b1;
                    end
                    default: ;
                endcase
                unique case (reg_addr_in)
                    8'h24: begin
                        st_d.out_pd[0] = reg_wdata_in[CCD_POS_PD];
                        st_d.shared_format_first_pair = reg_wdata_in[CCD_POS_FORMAT];
                        st_d.shared_amplitude_first_pair = reg_wdata_in[CCD_POS_AMP+:2];
                    end
                    8'h25: st_d.out_pd[1] = reg_wdata_in[CCD_POS_PD];
                    8'h26: begin
                        st_d.out_pd[2] = reg_wdata_in[CCD_POS_PD];
                        st_d.format_a2 = reg_wdata_in[CCD_POS_FORMAT];
                        st_d.amp_a2 = reg_wdata_in[CCD_POS_AMP+:2];
                    end
                    8'h34: begin
                        st_d.out_pd[3] = reg_wdata_in[CCD_POS_PD];
                        st_d.shared_format_second_channel = reg_wdata_in[CCD_POS_FORMAT];
                        st_d.shared_amplitude_second_channel = reg_wdata_in[CCD_POS_AMP+:2];
                    end
                    8'h35: st_d.out_pd[4] = reg_wdata_in[CCD_POS_PD];
                    8'h44: begin
                        st_d.out_pd[5] = reg_wdata_in[CCD_POS_PD];
                        st_d.format_c0 = reg_wdata_in[CCD_POS_FORMAT];
                        st_d.amp_c0 = reg_wdata_in[CCD_POS_AMP+:2];
                    end
                    8'h45: begin
                        st_d.out_pd[6] = reg_wdata_in[CCD_POS_PD];
                        st_d.format_c1 = reg_wdata_in[CCD_POS_FORMAT];
                        st_d.amp_c1 = reg_wdata_in[CCD_POS_AMP+:2];
                    end
                    8'h54: begin
                        st_d.out_pd[7] = reg_wdata_in[CCD_POS_PD];
                        st_d.format_d = reg_wdata_in[CCD_POS_FORMAT];
                        st_d.amp_d = reg_wdata_in[CCD_POS_AMP+:2];
                    end
                    default: ;
                endcase
            end
        end
        // Synchronous reset; the strap is sampled while reset is held
        if (!rstn_in) begin
            st_d.divider = {CCD_DIV_RESET_BYPASS, {CCD_DIV_RESET_MID_HI, middle_divider_default_strap_in},
                            {CCD_DIV_RESET_MID_HI, middle_divider_default_strap_in}, CCD_DIV_RESET_BYPASS};
            st_d.phase = {CCD_CHANNELS{CCD_PHASE_RESET}};
            st_d.ch_pd = {CCD_CHANNELS{CCD_PD_RESET}};
            st_d.out_pd = {CCD_OUTPUTS{CCD_PD_RESET}};
            {st_d.shared_format_first_pair, st_d.shared_format_second_channel, st_d.format_a2,
             st_d.format_c0, st_d.format_c1, st_d.format_d} = {6{CCD_FORMAT_RESET}};
            {st_d.shared_amplitude_first_pair, st_d.shared_amplitude_second_channel, st_d.amp_a2,
             st_d.amp_c0, st_d.amp_c1, st_d.amp_d} = {6{CCD_AMP_RESET}};
            st_d.enable = CCD_ENABLE_RESET;
            st_d.restart = '0;
            st_d.rdata = 8'h00;
            st_d.clk_out = '0;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        st_q <= st_d;
    end

    assign reg_rdata_out = st_q.rdata;
    assign clock_output_out = st_q.clk_out;
    assign output_lvpecl_out = fmt;
    assign output_level_out = lvl;
    assign output_active_out = ~st_q.out_pd;
endmodule

// File: core/ccd_pkg.sv
/*
 * Constants for the channel clock divider and clock output configuration block:
 * register addresses, field positions, reset values and the divider ratio table.
 * Assumes an 8-bit register space reached through the serial port's register back end.
 */
package ccd_pkg;
    localparam int CCD_CHANNELS = 4;
    localparam int CCD_OUTPUTS = 8;

    // Channel register bases, one block of 0x10 per channel
    localparam logic [7:0] CCD_CH_BASE_A = 8'h20;
    localparam logic [7:0] CCD_CH_STRIDE = 8'h10;
    localparam logic [3:0] CCD_OFS_DIVIDER = 4'h0;
    localparam logic [3:0] CCD_OFS_PHASE = 4'h1;
    localparam logic [3:0] CCD_OFS_CH_PD = 4'h2;
    localparam logic [3:0] CCD_OFS_OUT0 = 4'h4;
    localparam logic [3:0] CCD_OFS_OUT1 = 4'h5;
    localparam logic [3:0] CCD_OFS_OUT2 = 4'h6;
    localparam logic [7:0] CCD_ADDR_ENABLE = 8'h74;

    // Field positions
    localparam int CCD_POS_PD = 7;
    localparam int CCD_POS_FORMAT = 4;
    localparam int CCD_POS_AMP = 2;

    // Reset values
    localparam logic [3:0] CCD_DIV_RESET_BYPASS = 4'h0;
    localparam logic [2:0] CCD_DIV_RESET_MID_HI = 3'h1;
    localparam logic [7:0] CCD_PHASE_RESET = 8'h00;
    localparam logic CCD_PD_RESET = 1'b0;
    localparam logic CCD_FORMAT_RESET = 1'b0;
    localparam logic [1:0] CCD_AMP_RESET = 2'h1;
    localparam logic [7:0] CCD_ENABLE_RESET = 8'hff;

    // Effective output level codes
    localparam logic [1:0] CCD_LVL_350 = 2'h0;
    localparam logic [1:0] CCD_LVL_750 = 2'h1;
    localparam logic [1:0] CCD_LVL_1000 = 2'h2;
    localparam logic [1:0] CCD_LVL_UNDEF = 2'h3;

    // Ratio code decode, zero means bypass
    function automatic logic [4:0] ccd_ratio(input logic [3:0] code);
        logic [4:0] r;
        r = 5'h01;
        unique case (code)
            4'h1: r = 5'h02;
            4'h2: r = 5'h03;
            4'h3: r = 5'h04;
            4'h4: r = 5'h06;
            4'h5: r = 5'h08;
            4'h6: r = 5'h0c;
            4'h7: r = 5'h10;
            4'h8: r = 5'h18;
            default: r = 5'h01;
        endcase
        return r;
    endfunction
endpackage

// File: core/ccd_chan_if.sv
/*
 * Carrier between the configuration top and one channel divider.
 * Assumes both ends share clk_sys_in.
 */
`timescale 1ns/1ps
interface ccd_chan_if;
    logic [3:0] ratio_code;
    logic [7:0] phase_delay;
    logic power_down;
    logic restart;
    logic tick;
    logic running;

    modport ctrl (output ratio_code, output phase_delay, output power_down, output restart,
                  input tick, input running);
    modport chan (input ratio_code, input phase_delay, input power_down, input restart,
                  output tick, output running);
endinterface

// File: core/ccd_channel.sv
/*
 * One channel: coarse phase delay in input periods, then a divider that
 * emits a one-cycle tick per output period (every cycle in bypass).
 * Assumes clk_sys_in is the input clock of the channel.
 */
`timescale 1ns/1ps
module ccd_channel (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Configuration and status
    ccd_chan_if.chan ch
);
    import ccd_pkg::*;

    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] dly;
        logic run;
        logic tick;
    } ccd_chan_st_t;

    ccd_chan_st_t st_q, st_d;
    logic [4:0] ratio;

    // Divider state update
    always_comb begin
        st_d = st_q;
        ratio = ccd_ratio(ch.ratio_code);
        st_d.tick = 1'b0;
        if (!rstn_in || ch.power_down || ch.restart) begin
            st_d.cnt = 5'h00;
            st_d.dly = ch.phase_delay;
            st_d.run = 1'b0;
        end else if (!st_q.run) begin
            if (st_q.dly == 8'h00) begin
                st_d.run = 1'b1;
                st_d.tick = 1'b1;
                st_d.cnt = (ratio == 5'h01) ? 5'h00 : 5'h01;
            end else begin
                st_d.dly = st_q.dly - 8'h01;
            end
        end else begin
            st_d.tick = (st_q.cnt == 5'h00);
            st_d.cnt = (st_q.cnt + 5'h01 >= ratio) ? 5'h00 : st_q.cnt + 5'h01;
        end
        if (!rstn_in) begin
            st_d.dly = CCD_PHASE_RESET;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        st_q <= st_d;
    end

    assign ch.tick = st_q.tick;
    assign ch.running = st_q.run;
endmodule

// File: testbench/ccd_top_props.sv
/* Port checker for ccd_top.
   Assumes a bind to ccd_top and one clock domain. */
`timescale 1ns/1ps
module ccd_top_props
    import ccd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Register side
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Output status
    input wire logic [ccd_pkg::CCD_OUTPUTS-1:0] clock_output_out,
    input wire logic [ccd_pkg::CCD_OUTPUTS-1:0] output_lvpecl_out,
    input wire logic [2*ccd_pkg::CCD_OUTPUTS-1:0] output_level_out,
    input wire logic [ccd_pkg::CCD_OUTPUTS-1:0] output_active_out,
    input wire logic [ccd_pkg::CCD_CHANNELS-1:0] channel_running_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    // Channel D restart with a four-period delay
    sequence s_phase4_d;
        reg_wr_in && reg_addr_in == 8'h51 && reg_wdata_in == 8'h04;
    endsequence
    // Held off for the restart cycle plus four periods, then running
    sequence s_wait_run;
        (!channel_running_out[3])[*5] ##1 channel_running_out[3];
    endsequence
    // Read data is a one-cycle pulse
    chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero when idle");
    chk_reset_vals: assert property ($rose(rstn_in) |-> output_active_out == 8'hff && output_lvpecl_out == 8'h00
        && output_level_out == 16'h5555 && clock_output_out == 8'h00)
        else $error("output state wrong after reset");
    chk_fmt_pair: assert property (output_lvpecl_out[0] == output_lvpecl_out[1]
        && output_lvpecl_out[3] == output_lvpecl_out[4])
        else $error("shared format differs within pair");
    chk_amp_pair: assert property (output_level_out[1:0] == output_level_out[3:2]
        && output_level_out[7:6] == output_level_out[9:8])
        else $error("shared level differs within pair");
    chk_lvds_level: assert property (!output_lvpecl_out[7] |-> output_level_out[15:14] != CCD_LVL_1000)
        else $error("high level reported in low swing format");
    chk_pecl_level: assert property (output_lvpecl_out[7] |-> output_level_out[15:14] != CCD_LVL_UNDEF)
        else $error("undefined level in high swing format");
    chk_pd_gate: assert property ((!output_active_out[7])[*2] |-> !clock_output_out[7])
        else $error("powered down output toggles");
    chk_stop_gate: assert property ((!channel_running_out[3])[*2] |-> !clock_output_out[7])
        else $error("stopped channel output toggles");
    chk_phase_wait: assert property (s_phase4_d |-> ##2 s_wait_run)
        else $error("phase wait length wrong");
    chk_phase_store: assert property (reg_wr_in && reg_addr_in == 8'h31 ##2 reg_rd_in && reg_addr_in == 8'h31
        |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("phase register read back wrong");
endmodule

// File: testbench/ccd_conv_model.sv
/* Receiving converter: measures one clock output.
   Assumes the output is sampled on clk_sys_in. */
`timescale 1ns/1ps
module ccd_conv_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Received clock
    input wire logic clk_rx_in,
    // Measurements
    output logic [7:0] period_out,
    output logic [15:0] edges_out
);
    logic [7:0] gap_q;
    // Gap between ticks; edge count exposes gating
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            gap_q <= 8'h00;
            period_out <= 8'h00;
            edges_out <= 16'h0000;
        end else if (clk_rx_in) begin
            period_out <= gap_q + 8'h01;
            gap_q <= 8'h00;
            edges_out <= edges_out + 16'h0001;
        end else begin
            gap_q <= gap_q + 8'h01;
        end
    end
endmodule

// File: testbench/testbench.sv
/* Self-checking bench for ccd_top.
   Assumes drive on falling edges, results on registered outputs. */
`timescale 1ns/1ps
module testbench;
    import ccd_pkg::*;
    logic clk_sys_in, rstn_in, strap, wr, rd, rd_d;
    logic [7:0] addr, wdata, rdata, clk_o, pecl, act, period, r;
    logic [15:0] lvl, edges;
    logic [3:0] run;
    logic [7:0] exp_q[$];
    int err_total, samples_checked, cyc, n;
    integer seed = 32'hf1e8;
    logic [7:0] ra [17] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h34, 8'h35,
        8'h44, 8'h45, 8'h54, 8'h74, 8'h23, 8'h80};
    logic [7:0] re [17] = '{8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h04, 8'h04, 8'h00,
        8'h04, 8'h04, 8'h04, 8'hff, 8'h00, 8'h00};
    logic [7:0] ratio [9] = '{8'd1, 8'd2, 8'd3, 8'd4, 8'd6, 8'd8, 8'd12, 8'd16, 8'd24};
    logic [7:0] ph [3] = '{8'd4, 8'd0, 8'd255};
    logic [7:0] ga [3] = '{8'h54, 8'h74, 8'h52};
    logic [7:0] gon [3] = '{8'h84, 8'hfe, 8'h80};
    logic [7:0] goff [3] = '{8'h04, 8'hff, 8'h00};
    // Channel power-down release restarts the divider, which costs one output edge
    logic [7:0] gres [3] = '{8'd15, 8'd15, 8'd14};

    ccd_top u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .middle_divider_default_strap_in(strap),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .clock_output_out(clk_o), .output_lvpecl_out(pecl), .output_level_out(lvl),
        .output_active_out(act), .channel_running_out(run));
    ccd_conv_model u_conv (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .clk_rx_in(clk_o[7]),
        .period_out(period), .edges_out(edges));

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_rd(input logic [7:0] e, input logic [7:0] s);
        chk("read data", {8'h00, e}, {8'h00, s});
    endtask
    // Bus tasks: entered at a falling edge, strobe for one cycle, then one idle
    // cycle so a strobe never drops and rises again in one time step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_sys_in);
        wr = 1'b0;
        @(negedge clk_sys_in);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk_sys_in);
        rd = 1'b0;
        @(negedge clk_sys_in);
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rstn_in = 1'b1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // Read results land one cycle after the strobe
    always @(posedge clk_sys_in) rd_d <= rd && rstn_in;
    always @(negedge clk_sys_in) begin
        if (rd_d) begin
            chk_rd(exp_q.pop_front(), rdata);
        end
    end
    // Hang guard, far above the roughly 1100 cycles needed
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        {addr, wdata, wr, rd, rd_d, cyc, err_total, samples_checked} = '0;
        do_reset(1'b1);
        foreach (ra[i]) rd_reg(ra[i], re[i]);
        do_reset(1'b0);
        rd_reg(8'h30, 8'h02);
        rd_reg(8'h40, 8'h02);
        wr_reg(8'h20, 8'hff);
        rd_reg(8'h20, 8'h0f);
        foreach (ratio[c]) begin
            wr_reg(8'h50, 8'(c));
            repeat (60) @(negedge clk_sys_in);
            chk("period", {8'h00, ratio[c]}, {8'h00, period});
        end
        wr_reg(8'h50, 8'h00);
        foreach (ph[i]) begin
            wr_reg(8'h51, ph[i]);
            // Restart costs three edges, the output flop one more
            repeat (2) @(negedge clk_sys_in);
            n = 4;
            while (!clk_o[7] && n < 400) begin
                @(negedge clk_sys_in);
                n++;
            end
            chk("phase wait", {8'h00, ph[i]} + 16'd4, n[15:0]);
        end
        // Random phase codes, read straight back
        repeat (4) begin
            r = 8'($random(seed));
            wr_reg(8'h31, r);
            rd_reg(8'h31, r);
        end
        // Phase back to zero so the gating runs see a live channel
        wr_reg(8'h51, 8'h00);
        wr_reg(8'h50, 8'h01);
        foreach (ga[i]) begin
            wr_reg(ga[i], gon[i]);
            repeat (4) @(negedge clk_sys_in);
            n = edges;
            repeat (30) @(negedge clk_sys_in);
            chk("gated edges", n[15:0], edges);
            wr_reg(ga[i], goff[i]);
            repeat (30) @(negedge clk_sys_in);
            chk("resumed edges", n[15:0] + {8'h00, gres[i]}, edges);
        end
        // Reserved codes stay unused in low swing format
        for (int f = 0; f < 2; f++) begin
            for (int a = 0; a < 4; a++) begin
                if (f == 1 || a < 2) begin
                    wr_reg(8'h54, 8'((f << 4) | (a << 2)));
                    chk("level D", (a > 1) ? 16'd2 : 16'(a), {14'd0, lvl[15:14]});
                    chk("format D", 16'(f), {15'd0, pecl[7]});
                end
            end
        end
        wr_reg(8'h24, 8'h18);
        wr_reg(8'h34, 8'h10);
        wr_reg(8'h25, 8'h10);
        // Output D was left in high swing format by the level loop
        chk("pair format", 16'h009b, {8'h00, pecl});
        chk("pair level", 16'h001a, {6'd0, lvl[9:0]});
        rd_reg(8'h25, 8'h00);
        repeat (3) @(negedge clk_sys_in);
        tally_and_finish();
    end
endmodule

bind ccd_top ccd_top_props u_props (.clk_sys_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .clock_output_out, .output_lvpecl_out, .output_level_out,
    .output_active_out, .channel_running_out);
